// file: rtl/pc_irq_pkg.sv
package pc_irq_pkg;
    // Widths
    localparam int unsigned PC_W       = 13;
    localparam int unsigned HOLD_W     = 5;
    localparam int unsigned TARGET_W   = 11;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned DADDR_W    = 9;
    localparam int unsigned APB_AW     = 10;
    localparam int unsigned APB_DW     = 32;
    localparam int unsigned N_SRC      = 3;
    localparam int unsigned STACK_DEPTH = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_WINDOW      = 8'h00;
    localparam logic [7:0] IDX_PC_LOW      = 8'h02;
    localparam logic [7:0] IDX_POINTER     = 8'h04;
    localparam logic [7:0] IDX_HOLDING     = 8'h0a;
    localparam logic [7:0] IDX_IRQ_CTRL    = 8'h0b;
    localparam logic [7:0] IDX_RESET_CAUSE = 8'h8e;

    // Interrupt control fields
    localparam int unsigned GIE_BIT  = 7;
    localparam int unsigned EN_LSB   = 3;
    localparam int unsigned FLAG_LSB = 0;
    localparam logic [7:0]  IRQ_CTRL_RST = 8'h00;

    // Reset cause fields (a zero marks the cause)
    localparam int unsigned POR_N_BIT = 1;
    localparam int unsigned WDT_N_BIT = 0;
    localparam logic [1:0]  CAUSE_RST = 2'h0;

    // Program counter values
    localparam logic [PC_W-1:0]   PC_RST      = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP     = 13'h0001;
    localparam logic [PC_W-1:0]   IRQ_VECTOR  = 13'h0004;
    localparam logic [HOLD_W-1:0] HOLD_RST    = 5'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO   = 8'h00;
    localparam int unsigned       FAR_HI_LSB  = 3;
    localparam logic              IND_BANK    = 1'b0;

    // Start-up walk that waits out the cause synchronisers
    typedef enum logic [1:0]
    {
        CAP_WAIT0 = 2'b00,
        CAP_WAIT1 = 2'b01,
        CAP_WAIT2 = 2'b10,
        CAP_DONE  = 2'b11
    } cap_state_t;
endpackage

// file: rtl/return_stack.sv
`timescale 1ns/1ps
`default_nettype none
module return_stack
#(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned WIDTH = 13
)
(
    input  wire logic             sys_clk,   // System clock
    input  wire logic             rst_b,     // Async reset, active low
    input  wire logic             push,      // Store push_data
    input  wire logic             pop,       // Drop the top entry
    input  wire logic [WIDTH-1:0] push_data, // Address to save
    output logic      [WIDTH-1:0] top_data   // Most recently saved address
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    sp_r;
    logic [PW-1:0]    sp_nxt;
    logic [PW-1:0]    top_idx;

    // Pointer wraps silently; no overflow or underflow is flagged
    always_comb
    begin
        sp_nxt = sp_r;
        if (push)
        begin
            sp_nxt = sp_r + 1'b1; // R14 R15
        end
        else if (pop)
        begin
            sp_nxt = sp_r - 1'b1; // R14
        end
        top_idx = sp_r - 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sp_r <= '0;
        end
        else
        begin
            sp_r <= sp_nxt;
        end
    end

    // Entries need no reset; a ninth push overwrites the oldest
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[sp_r] <= push_data; // R10 R14
        end
    end

    assign top_data = mem[top_idx];
endmodule
`default_nettype wire

// file: rtl/pc_stack_irq_control.sv
// Overview of operation
// R01: Control register: global enable bit 7, bit 6 reserved, enables 5..3, flags 2..0.
// R02: A flag sets on its source event regardless of any enable bit.
// R03: Interrupt request only when global enable and some flag with enable set.
// R04: Reset cause bits tell power-on, master-clear and watchdog resets apart.
// R05: Program counter is 13 bits; low byte readable, upper bits from holding register.
// R06: Every reset clears the whole program counter.
// R07: Writing the low byte loads holding bits 4..0 into upper counter bits.
// R08: Call and jump take counter bits 12..11 from holding bits 4..3.
// R09: Software computed jumps must mind crossings of 256-byte blocks.
// R10: Eight-entry 13-bit return stack, pointer hidden from software.
// R11: Calls and interrupt vectoring push the program counter.
// R12: Return, return-with-literal and return-from-interrupt pop into the counter.
// R13: Pushes and pops leave the holding register untouched.
// R14: Stack is circular; ninth push overwrites first, tenth the second.
// R15: No stack overflow or underflow indication exists.
// R16: Accessing the indirect window reaches the location the pointer selects.
// R17: Window pointing at itself reads as zero.
// R18: Window pointing at itself writes nothing.
// R19: Indirect address is the zero bank bit above the 8-bit pointer.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_irq_control
    import pc_irq_pkg::*;
#(
    parameter logic [pc_irq_pkg::PC_W-1:0] VECTOR_ADDR = pc_irq_pkg::IRQ_VECTOR
)
(
    input  wire logic                                sys_clk,          // 50 MHz clock
    input  wire logic                                rst_b,            // Async reset
    input  wire logic [pc_irq_pkg::APB_AW-1:0]       paddr,            // APB address
    input  wire logic                                psel,             // APB select
    input  wire logic                                penable,          // APB enable
    input  wire logic                                pwrite,           // APB direction
    input  wire logic [pc_irq_pkg::APB_DW-1:0]       pwdata,           // APB write data
    output logic      [pc_irq_pkg::APB_DW-1:0]       prdata,           // APB read data
    output logic                                     pready,           // APB ready
    output logic                                     pslverr,          // APB error
    input  wire logic                                pc_advance,       // Step counter
    input  wire logic                                call_exec,        // Call
    input  wire logic                                goto_exec,        // Jump
    input  wire logic [pc_irq_pkg::TARGET_W-1:0]     jump_target,      // Target low bits
    input  wire logic                                return_exec,      // Return kinds
    input  wire logic                                return_irq_exec,  // Return from irq
    input  wire logic                                irq_vector_take,  // Branch to vector
    output logic      [pc_irq_pkg::PC_W-1:0]         pc_value,         // Program counter
    output logic                                     irq_request,      // Branch wanted
    input  wire logic                                timer_overflow_evt, // Source pulse
    input  wire logic                                ext_edge_evt,     // Source pulse
    input  wire logic                                port_change_evt,  // Source pulse
    input  wire logic                                por_cause_pin,    // Power-on seen
    input  wire logic                                wdt_cause_pin,    // Watchdog seen
    output logic                                     dmem_req,         // Data access
    output logic                                     dmem_we,          // Data write
    output logic      [pc_irq_pkg::DADDR_W-1:0]      dmem_addr,        // Data address
    output logic      [pc_irq_pkg::BYTE_W-1:0]       dmem_wdata,       // Data to write
    input  wire logic [pc_irq_pkg::BYTE_W-1:0]       dmem_rdata,       // Data read
    input  wire logic                                dmem_ack          // Data done
);
    import pc_irq_pkg::*;

    logic [BYTE_W-1:0]  irq_ctrl_r;
    logic [BYTE_W-1:0]  irq_ctrl_nxt;
    logic [N_SRC-1:0]   src_evt;
    logic [N_SRC-1:0]   flag_nxt;
    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    pc_nxt;
    logic [HOLD_W-1:0]  holding_r;
    logic [HOLD_W-1:0]  holding_nxt;
    logic [BYTE_W-1:0]  ptr_r;
    logic [BYTE_W-1:0]  ptr_nxt;
    logic [1:0]         cause_r;
    logic [1:0]         cause_nxt;
    cap_state_t         cap_r;
    cap_state_t         cap_nxt;
    logic [1:0]         cause_s1_r;
    logic [1:0]         cause_s2_r;
    logic [BYTE_W-1:0]  rdata_r;
    logic [BYTE_W-1:0]  rdata_nxt;
    logic               ind_done_r;
    logic               ind_done_nxt;
    logic               push;
    logic               pop;
    logic [PC_W-1:0]    stack_top;
    logic [7:0]         idx;
    logic               mapped;
    logic               setup;
    logic               access;
    logic               wr_fire;
    logic               ind_sel;
    logic               ind_self;
    logic               ind_ext;
    logic [BYTE_W-1:0]  rd_mux;

    // Address decode; any byte-misaligned access is unmapped
    assign idx    = paddr[APB_AW-1:2];
    assign mapped = (paddr[1:0] == 2'b00) &&
                    (idx == IDX_WINDOW || idx == IDX_PC_LOW || idx == IDX_POINTER ||
                     idx == IDX_HOLDING || idx == IDX_IRQ_CTRL || idx == IDX_RESET_CAUSE);
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign ind_sel  = mapped && (idx == IDX_WINDOW);
    assign ind_self = ind_sel && (ptr_r == IDX_WINDOW);           // R17 R18
    assign ind_ext  = ind_sel && !ind_self;                       // R16
    assign pready   = !ind_ext || ind_done_r;
    assign pslverr  = access && !mapped;
    assign wr_fire  = access && pwrite && pready && mapped;

    // Indirect path to data space; waits on the data side's ack
    assign dmem_req   = access && ind_ext && !ind_done_r;         // R16
    assign dmem_we    = pwrite;
    assign dmem_addr  = {IND_BANK, ptr_r};                        // R19
    assign dmem_wdata = pwdata[BYTE_W-1:0];

    // Read mux; counter upper bits are never visible
    always_comb
    begin
        rd_mux = BYTE_ZERO;
        case (idx)
            IDX_PC_LOW:      rd_mux = pc_r[BYTE_W-1:0];           // R05
            IDX_POINTER:     rd_mux = ptr_r;
            IDX_HOLDING:     rd_mux = {3'b000, holding_r};
            IDX_IRQ_CTRL:    rd_mux = irq_ctrl_r;
            IDX_RESET_CAUSE: rd_mux = {6'b00_0000, cause_r};      // R04
            default:         rd_mux = BYTE_ZERO;                  // R17
        endcase
    end

    // Read data captured in setup, or from data space on ack
    always_comb
    begin
        rdata_nxt    = rdata_r;
        ind_done_nxt = ind_done_r;
        if (setup)
        begin
            rdata_nxt = rd_mux;
        end
        if (dmem_req && dmem_ack)
        begin
            ind_done_nxt = 1'b1;
            if (!pwrite)
            begin
                rdata_nxt = dmem_rdata;
            end
        end
        if (access && pready)
        begin
            ind_done_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r    <= BYTE_ZERO;
            ind_done_r <= 1'b0;
        end
        else
        begin
            rdata_r    <= rdata_nxt;
            ind_done_r <= ind_done_nxt;
        end
    end

    assign prdata = {{(APB_DW-BYTE_W){1'b0}}, rdata_r};

    // Flags: event sets win over a software clear in the same cycle
    assign src_evt = {timer_overflow_evt, ext_edge_evt, port_change_evt};
    generate
        for (genvar i = 0; i < N_SRC; i++)
        begin : g_flag
            assign flag_nxt[i] =
                ((wr_fire && idx == IDX_IRQ_CTRL) ? pwdata[FLAG_LSB+i] : irq_ctrl_r[FLAG_LSB+i])
                | src_evt[i];                                     // R02
        end
    endgenerate

    // Global enable drops on vectoring and returns with return-from-irq
    always_comb
    begin
        irq_ctrl_nxt = irq_ctrl_r;
        if (wr_fire && idx == IDX_IRQ_CTRL)
        begin
            irq_ctrl_nxt[GIE_BIT]             = pwdata[GIE_BIT];  // R01
            irq_ctrl_nxt[EN_LSB+N_SRC-1:EN_LSB] = pwdata[EN_LSB+N_SRC-1:EN_LSB];
        end
        if (irq_vector_take)
        begin
            irq_ctrl_nxt[GIE_BIT] = 1'b0;
        end
        else if (return_irq_exec)
        begin
            irq_ctrl_nxt[GIE_BIT] = 1'b1;
        end
        irq_ctrl_nxt[GIE_BIT-1] = 1'b0;                           // R01
        irq_ctrl_nxt[FLAG_LSB+N_SRC-1:FLAG_LSB] = flag_nxt;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_ctrl_r <= IRQ_CTRL_RST;
        end
        else
        begin
            irq_ctrl_r <= irq_ctrl_nxt;
        end
    end

    assign irq_request = irq_ctrl_r[GIE_BIT] &&
        |(irq_ctrl_r[EN_LSB+N_SRC-1:EN_LSB] & irq_ctrl_r[FLAG_LSB+N_SRC-1:FLAG_LSB]); // R03

    // Counter sequencing; vectoring outranks the instruction in flight
    always_comb
    begin
        pc_nxt      = pc_r;
        push        = 1'b0;
        pop         = 1'b0;
        holding_nxt = holding_r;                                  // R13
        ptr_nxt     = ptr_r;
        if (wr_fire && idx == IDX_HOLDING)
        begin
            holding_nxt = pwdata[HOLD_W-1:0];
        end
        if (wr_fire && idx == IDX_POINTER)
        begin
            ptr_nxt = pwdata[BYTE_W-1:0];
        end
        if (irq_vector_take)
        begin
            push   = 1'b1;                                        // R11
            pc_nxt = VECTOR_ADDR;
        end
        else if (call_exec || goto_exec)
        begin
            push   = call_exec;                                   // R11
            pc_nxt = {holding_r[HOLD_W-1:FAR_HI_LSB], jump_target}; // R08
        end
        else if (return_exec || return_irq_exec)
        begin
            pop    = 1'b1;                                        // R12
            pc_nxt = stack_top;
        end
        else if (wr_fire && idx == IDX_PC_LOW)
        begin
            pc_nxt = {holding_r, pwdata[BYTE_W-1:0]};             // R07
        end
        else if (pc_advance)
        begin
            pc_nxt = pc_r + PC_STEP;
        end
    end

    // Every reset kind arrives on rst_b and clears the counter
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pc_r      <= PC_RST;                                  // R06
            holding_r <= HOLD_RST;
            ptr_r     <= BYTE_ZERO;
        end
        else
        begin
            pc_r      <= pc_nxt;
            holding_r <= holding_nxt;
            ptr_r     <= ptr_nxt;
        end
    end

    assign pc_value = pc_r;

    return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W)
    ) u_stack (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .push      (push),
        .pop       (pop),
        .push_data (pc_r),
        .top_data  (stack_top)
    );

    // Cause pins come from the reset logic, so they are synchronised
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cause_s1_r <= 2'b00;
            cause_s2_r <= 2'b00;
        end
        else
        begin
            cause_s1_r <= {por_cause_pin, wdt_cause_pin};
            cause_s2_r <= cause_s1_r;
        end
    end

    // Cause is caught once after release; software may then rewrite it
    always_comb
    begin
        cap_nxt   = cap_r;
        cause_nxt = cause_r;
        case (cap_r)
            CAP_WAIT0: cap_nxt = CAP_WAIT1;
            CAP_WAIT1: cap_nxt = CAP_WAIT2;
            CAP_WAIT2:
            begin
                cap_nxt = CAP_DONE;
                cause_nxt[POR_N_BIT] = !cause_s2_r[1];            // R04
                cause_nxt[WDT_N_BIT] = !cause_s2_r[0] || cause_s2_r[1];
            end
            CAP_DONE:
            begin
                if (wr_fire && idx == IDX_RESET_CAUSE)
                begin
                    cause_nxt = pwdata[1:0];
                end
            end
            default: cap_nxt = CAP_DONE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_r   <= CAP_WAIT0;
            cause_r <= CAUSE_RST;
        end
        else
        begin
            cap_r   <= cap_nxt;
            cause_r <= cause_nxt;
        end
    end

    // Checks
    a_flag_set_event: assert property (@(posedge sys_clk) disable iff (!rst_b) // R02
        timer_overflow_evt |=> irq_ctrl_r[FLAG_LSB+2])
        else $error("flag missed its event");
    a_irq_from_event: assert property (@(posedge sys_clk) disable iff (!rst_b) // R02 R03
        irq_ctrl_r[GIE_BIT] && (src_evt & irq_ctrl_r[5:3]) != 3'b000 && !irq_vector_take
        && !(wr_fire && idx == IDX_IRQ_CTRL) |=> irq_request)
        else $error("event did not raise request");
    a_pc_low_load: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
        (wr_fire && idx == IDX_PC_LOW && !irq_vector_take && !call_exec && !goto_exec
         && !return_exec && !return_irq_exec)
        |=> pc_r == {$past(holding_r), $past(pwdata[7:0])})
        else $error("low byte write load wrong");
    a_call_upper_bits: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
        (call_exec && !irq_vector_take) |=> pc_r[12:11] == $past(holding_r[4:3])
        && pc_r[10:0] == $past(jump_target))
        else $error("call target wrong");
    a_call_return_pair: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11 R12
        (call_exec && !irq_vector_take) ##1 (return_exec && !irq_vector_take
        && !call_exec && !goto_exec) |=> pc_r == $past(pc_r, 2))
        else $error("return address lost");
    a_holding_kept: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
        (push || pop) && !(wr_fire && idx == IDX_HOLDING) |=> $stable(holding_r))
        else $error("holding changed by stack");
    a_window_self: assert property (@(posedge sys_clk) disable iff (!rst_b) // R17 R18
        (access && ind_self) |-> !dmem_req && pready ##1 (pwrite || prdata == 32'h0000_0000))
        else $error("self window access wrong");
    a_indirect_addr: assert property (@(posedge sys_clk) disable iff (!rst_b) // R16 R19
        dmem_req |-> dmem_addr == {1'b0, ptr_r} && ptr_r != IDX_WINDOW)
        else $error("indirect address wrong");
endmodule
`default_nettype wire

// file: test/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
    import pc_irq_pkg::*;
(
    input  wire logic                             sys_clk,    // Clock
    input  wire logic                             rst_b,      // Async reset
    input  wire logic                             slow,       // Stretch each answer
    input  wire logic                             dmem_req,   // Access pending
    input  wire logic                             dmem_we,    // Write access
    input  wire logic [pc_irq_pkg::DADDR_W-1:0]   dmem_addr,  // Byte address
    input  wire logic [pc_irq_pkg::BYTE_W-1:0]    dmem_wdata, // Data to store
    output logic      [pc_irq_pkg::BYTE_W-1:0]    dmem_rdata, // Read data
    output logic                                  dmem_ack    // One-cycle answer
);
    logic [BYTE_W-1:0] mem [0:511];
    int unsigned       wait_cnt;

    // Known fill so a stray write shows up
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = 8'h5a ^ 8'(i);
    end

    // Read data is only valid with ack; it wanders otherwise so nobody leans on it
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dmem_ack <= 1'b0;
            wait_cnt <= 0;
            dmem_rdata <= 8'h00;
        end
        else if (dmem_ack)
        begin
            dmem_ack <= 1'b0;
            dmem_rdata <= ~dmem_rdata;
        end
        else if (dmem_req && wait_cnt >= (slow ? 3 : 0))
        begin
            dmem_ack <= 1'b1;
            wait_cnt <= 0;
            dmem_rdata <= mem[dmem_addr];
            if (dmem_we)
                mem[dmem_addr] <= dmem_wdata;
        end
        else
        begin
            wait_cnt <= dmem_req ? wait_cnt + 1 : 0;
            dmem_rdata <= dmem_rdata + 8'h3b;
        end
    end
endmodule
`default_nettype wire

// file: test/pc_stack_irq_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("BAD %s expected %h seen %h", nm, exp, got); \
        end \
    end
module pc_stack_irq_control_tb_top;
    import pc_irq_pkg::*;
    logic                sys_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic [APB_AW-1:0]   paddr = '0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [APB_DW-1:0]   pwdata = '0;
    logic [APB_DW-1:0]   prdata;
    logic                pready, pslverr, irq_request, dmem_req, dmem_we, dmem_ack;
    logic [5:0]          op = '0;  // Advance, call, goto, return, irq return, vector
    logic [TARGET_W-1:0] jump_target = '0;
    logic [PC_W-1:0]     pc_value;
    logic [2:0]          evts = '0;  // Timer, external edge, port change
    logic                por_cause_pin = 1'b1;
    logic                wdt_cause_pin = 1'b0;
    logic                slow = 1'b0;
    logic [DADDR_W-1:0]  dmem_addr;
    logic [BYTE_W-1:0]   dmem_wdata, dmem_rdata, p, b;
    int                  failures = 0;
    int                  samples_checked = 0;
    int                  dep = 0;
    logic [PC_W-1:0]     mpc, stk [0:7];
    logic [2:0]          sp;
    logic [4:0]          mhold;
    logic [31:0]         rd;
    logic                er, rdy;

    always #10 sys_clk = ~sys_clk;

    pc_stack_irq_control u_pc_stack_irq_control
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc_advance(op[0]), .call_exec(op[1]), .goto_exec(op[2]),
        .jump_target(jump_target), .return_exec(op[3]), .return_irq_exec(op[4]),
        .irq_vector_take(op[5]), .pc_value(pc_value), .irq_request(irq_request),
        .timer_overflow_evt(evts[2]), .ext_edge_evt(evts[1]), .port_change_evt(evts[0]),
        .por_cause_pin(por_cause_pin), .wdt_cause_pin(wdt_cause_pin),
        .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_ack(dmem_ack)
    );

    data_mem_model u_data_mem_model
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .slow(slow), .dmem_req(dmem_req),
        .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata), .dmem_ack(dmem_ack)
    );

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic endt(input string nm);
        $display("test %s done", nm);
    endtask

    // Request held until pready is seen; answer taken at that same rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            rdy = pready;
            rd = prdata;
            er = pslverr;
            n++;
        end
        while (!rdy && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (!rdy)
        begin
            failures++;
            stop_test();
        end
    endtask

    // Junk in the upper lanes must be ignored
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'ha5_a5a5, d});
        @(negedge sys_clk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        `CHK(nm, {24'h00_0000, exp}, rd)
    endtask

    // One strobe; the bench model of counter and stack moves alongside
    task automatic cpu(input int k, input logic [10:0] t);
        @(posedge sys_clk);
        op <= 6'b00_0001 << k;
        jump_target <= t;
        @(posedge sys_clk);
        op <= '0;
        if (k == 1 || k == 5)
        begin
            stk[sp] = mpc;
            sp++;
            dep = (dep < 8) ? dep + 1 : 8;
        end
        if (k == 3 || k == 4)
        begin
            sp--;
            mpc = stk[sp];
            dep--;
        end
        else if (k == 0)
            mpc++;
        else
            mpc = (k == 5) ? IRQ_VECTOR : {mhold[4:3], t};
        @(negedge sys_clk);
        `CHK("pc_value", mpc, pc_value)
    endtask

    task automatic do_reset(input logic por, input logic wdt);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        por_cause_pin <= por;
        wdt_cause_pin <= wdt;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        mpc = PC_RST;
        sp = 3'h0;
        mhold = HOLD_RST;
        dep = 0;
        repeat (4) @(posedge sys_clk);
    endtask

    initial
    begin
        void'($urandom(15047));
        // Power-on, watchdog, then master clear
        for (int i = 0; i < 3; i++)
        begin
            do_reset(i == 0, i == 1);
            `CHK("pc_value", PC_RST, pc_value)
            rdchk(IDX_RESET_CAUSE, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h03, "cause");
            rdchk(IDX_IRQ_CTRL, IRQ_CTRL_RST, "irq_control");
        end
        endt("reset");
        // First pass sets low byte to ff so the step crosses a 256 block
        for (int i = 0; i < 8; i++)
        begin
            mhold = 5'($urandom);
            b = (i == 0) ? 8'hff : 8'($urandom);
            wr(IDX_HOLDING, {3'h0, mhold});
            wr(IDX_PC_LOW, b);
            mpc = {mhold, b};
            `CHK("pc_value", mpc, pc_value)
            rdchk(IDX_PC_LOW, b, "pc_low");
            cpu(0, '0);
        end
        endt("counter");
        for (int i = 0; i < 10; i++)
            cpu(1, 11'($urandom));
        for (int i = 0; i < 8; i++)
            cpu(3, '0);
        rdchk(IDX_HOLDING, {3'h0, mhold}, "holding");
        // Call then return on adjacent edges; the call's own address comes back
        @(posedge sys_clk);
        op <= 6'b00_0010;
        @(posedge sys_clk);
        op <= 6'b00_1000;
        @(posedge sys_clk);
        op <= '0;
        stk[sp] = mpc;
        @(negedge sys_clk);
        `CHK("pc_value", mpc, pc_value)
        for (int i = 0; i < 60; i++)
            cpu((dep == 0) ? 1 : $urandom_range(3), 11'($urandom));
        endt("stack");
        for (int i = 0; i < 3; i++)
        begin
            wr(IDX_IRQ_CTRL, 8'h00);
            @(posedge sys_clk);
            evts <= 3'b100 >> i;
            @(posedge sys_clk);
            evts <= 3'b000;
            @(negedge sys_clk);
            `CHK("irq_request", 1'b0, irq_request)
            rdchk(IDX_IRQ_CTRL, 8'h04 >> i, "irq_flag");
            wr(IDX_IRQ_CTRL, 8'h80 | (8'h24 >> i));
            `CHK("irq_request", 1'b1, irq_request)
            wr(IDX_IRQ_CTRL, 8'h80 | (8'h20 >> i));
            `CHK("irq_request", 1'b0, irq_request)
        end
        wr(IDX_IRQ_CTRL, 8'hff);
        rdchk(IDX_IRQ_CTRL, 8'hbf, "irq_control");
        cpu(5, '0);
        `CHK("irq_request", 1'b0, irq_request)
        cpu(4, '0);
        `CHK("irq_request", 1'b1, irq_request)
        // Event arriving while already enabled raises the request directly
        wr(IDX_IRQ_CTRL, 8'hb8);
        @(posedge sys_clk);
        evts <= 3'b010;
        @(posedge sys_clk);
        evts <= 3'b000;
        @(negedge sys_clk);
        `CHK("irq_request", 1'b1, irq_request)
        endt("irq");
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            p = 8'h01 + 8'($urandom_range(254));
            b = 8'($urandom);
            wr(IDX_POINTER, p);
            wr(IDX_WINDOW, b);
            `CHK("mem", b, u_data_mem_model.mem[{IND_BANK, p}])
            rdchk(IDX_WINDOW, b, "window");
        end
        wr(IDX_POINTER, 8'h00);
        wr(IDX_WINDOW, 8'h99);
        `CHK("mem0", 8'h5a, u_data_mem_model.mem[0])
        rdchk(IDX_WINDOW, 8'h00, "window_self");
        apb(1'b0, 8'hff, 32'h0000_0000);
        `CHK("pslverr", 1'b1, er)
        endt("indirect");
        stop_test();
    end
endmodule
`default_nettype wire
